// file: verilog/dces_pkg.sv
// Package with register map, field positions and codes of the draw command setup block.
// Functional notes
// - With auto launch off, writing the command word starts the command.
// - With auto launch on, writing the type's last parameter register starts it.
// - Command word with auto launch off and no-op code draws nothing.
// - Clip bounds are applied only while clip enable is set.
// - Target format 000 is 8 bit, 001 is 16 bit, 010 is 24 bit.
// - Pixel write enable off runs the command fully but writes no pixels.
// - Host image source takes source bytes from host image window writes.
// - Mono pattern select picks mono registers, else colour pattern memory.
// - Transparent mono host transfer writes only pixels whose image bit is one.
// - Transparent colour transfer skips key-colour pixels, at every format but 24 bit.
// - Image data arrives as doublewords; line alignment byte, word or doubleword.
// - Line end: doubleword drops rest, word keeps upper word, byte continues.
// - First byte skip drops zero to three leading bytes of first doubleword.
// - Block writes used only when inhibit is clear and global enable set.
// - Eight bit raster operation key selects one of 256 operations.
// - Fill, line and polygon force pattern to pattern foreground colour.
// - Copy direction bits: one means left to right and top to bottom.
// - Operation code decodes copy, fill, line, polygon and no-op; bit 31 is 3D.
// - Rectangle size holds 11 bit height and 11 bit width minus one.
// - Copy source origin holds 11 bit y and x of the upper left corner.
package dces_pkg;
    localparam logic [31:0] OFS_CMD = 32'h0000_A500;
    localparam logic [31:0] OFS_RECT_SIZE = 32'h0000_A504;
    localparam logic [31:0] OFS_SRC_ORIGIN = 32'h0000_A508;
    localparam logic [31:0] OFS_TGT_ORIGIN = 32'h0000_A50C;
    localparam logic [31:0] OFS_SRC_FG = 32'h0000_A4FC;
    localparam logic [31:0] OFS_LINE_SCAN = 32'h0000_A97C;
    localparam logic [31:0] OFS_POLY_LAST = 32'h0000_AD7C;
    localparam logic [31:0] OFS_STATUS = 32'h0000_A5F0;
    localparam logic [31:0] IMG_WIN0_LO = 32'h0100_0000;
    localparam logic [31:0] IMG_WIN0_HI = 32'h0100_7FFF;
    localparam logic [31:0] IMG_WIN1_LO = 32'h0100_D000;
    localparam logic [31:0] IMG_WIN1_HI = 32'h0100_EFFF;
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [31:0] CMD_MASK = 32'hFFFF_3FFF;
    localparam logic [31:0] XY_MASK = 32'h07FF_07FF;
    localparam logic [31:0] COLOUR_MASK = 32'h00FF_FFFF;
    localparam int AUTO_BIT = 0;
    localparam int CLIP_BIT = 1;
    localparam int FMT_LSB = 2;
    localparam int PIXWR_BIT = 5;
    localparam int MONO_SRC_BIT = 6;
    localparam int HOST_SRC_BIT = 7;
    localparam int MONO_PAT_BIT = 8;
    localparam int TRANSP_BIT = 9;
    localparam int ALIGN_LSB = 10;
    localparam int SKIP_LSB = 12;
    localparam int BW_INHIBIT_BIT = 16;
    localparam int ROP_LSB = 17;
    localparam int XFWD_BIT = 25;
    localparam int YFWD_BIT = 26;
    localparam int OP_LSB = 27;
    localparam int DIM_BIT = 31;
    localparam int X_LSB = 16;
    localparam logic [3:0] OP_COPY = 4'h0;
    localparam logic [3:0] OP_FILL = 4'h2;
    localparam logic [3:0] OP_LINE = 4'h3;
    localparam logic [3:0] OP_POLY = 4'h5;
    localparam logic [3:0] OP_NOP = 4'hF;
    localparam logic [2:0] FMT_8 = 3'h0;
    localparam logic [2:0] FMT_16 = 3'h1;
    localparam logic [2:0] FMT_24 = 3'h2;
    localparam logic [1:0] ALIGN_BYTE = 2'h0;
    localparam logic [1:0] ALIGN_WORD = 2'h1;
    localparam logic [1:0] ALIGN_DWORD = 2'h2;
    localparam logic [2:0] PTR_END = 3'h4;
    localparam logic [2:0] PTR_UPPER = 3'h2;
endpackage

// file: verilog/dces_top.sv
// APB register file, launch logic and host image byte unpacker of the draw command setup block.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module dces_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_block_write_enable,
    output logic launch,
    output logic [3:0] launch_op,
    output logic dimension_select,
    output logic clip_enable,
    output logic [2:0] target_pixel_format,
    output logic format_reserved,
    output logic pixel_write_enable,
    output logic host_image_source,
    output logic mono_source_select,
    output logic mono_pattern_select,
    output logic pattern_force_fg,
    output logic mono_transparent,
    output logic colour_key_enable,
    output logic block_write_use,
    output logic [7:0] raster_operation_key,
    output logic x_forward,
    output logic y_forward,
    output logic [10:0] rect_height,
    output logic [10:0] rect_width,
    output logic [10:0] src_x,
    output logic [10:0] src_y,
    output logic [10:0] tgt_x,
    output logic [10:0] tgt_y,
    output logic [23:0] source_foreground_colour,
    output logic img_byte_valid,
    output logic [7:0] img_byte,
    output logic img_line_end
);
    logic [31:0] cmd_r;
    logic [31:0] size_r;
    logic [31:0] src_r;
    logic [31:0] tgt_r;
    logic [31:0] fg_r;
    logic [31:0] line_scan_r;
    logic [31:0] poly_last_r;
    logic [15:0] launch_cnt_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic launch_r;
    logic [3:0] launch_op_r;
    logic bw_use_r;
    logic [31:0] img_word_r;
    logic [2:0] ptr_r;
    logic first_dword_r;
    logic [12:0] line_left_r;
    logic byte_valid_r;
    logic [7:0] byte_r;
    logic line_end_r;
    logic access;
    logic wr_fire;
    logic hit_img;
    logic hit_reg;
    logic unpack_busy;
    logic [3:0] wr_op;
    logic wr_auto;
    logic launch_nxt;
    logic [12:0] line_bytes;
    logic [2:0] ptr_after_line;
    logic at_line_end;
    logic [31:0] cmd_nxt;
    logic pff_r;
    logic fres_r;
    logic mtr_r;
    logic cke_r;

    // Address decode; the image windows accept writes only.
    assign access = psel & penable;
    assign hit_img = ((paddr >= dces_pkg::IMG_WIN0_LO) && (paddr <= dces_pkg::IMG_WIN0_HI)) ||
                     ((paddr >= dces_pkg::IMG_WIN1_LO) && (paddr <= dces_pkg::IMG_WIN1_HI));
    assign hit_reg = (paddr == dces_pkg::OFS_CMD) || (paddr == dces_pkg::OFS_RECT_SIZE) ||
                     (paddr == dces_pkg::OFS_SRC_ORIGIN) || (paddr == dces_pkg::OFS_TGT_ORIGIN) ||
                     (paddr == dces_pkg::OFS_SRC_FG) || (paddr == dces_pkg::OFS_LINE_SCAN) ||
                     (paddr == dces_pkg::OFS_POLY_LAST) || (paddr == dces_pkg::OFS_STATUS);
    assign unpack_busy = (ptr_r != dces_pkg::PTR_END);
    assign wr_fire = access & pready_r & pwrite;

    // One wait state per transfer; an image write also waits until the previous doubleword is drained.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= dces_pkg::RST_REG;
        end else begin
            pready_r <= access & ~pready_r & ~(hit_img & pwrite & unpack_busy);
            if (access & ~pready_r) begin
                pslverr_r <= ~(hit_reg | (hit_img & pwrite));
                prdata_r <= dces_pkg::RST_REG;
                if (!pwrite) begin
                    unique case (paddr)
                        dces_pkg::OFS_CMD: prdata_r <= cmd_r;
                        dces_pkg::OFS_RECT_SIZE: prdata_r <= size_r;
                        dces_pkg::OFS_SRC_ORIGIN: prdata_r <= src_r;
                        dces_pkg::OFS_TGT_ORIGIN: prdata_r <= tgt_r;
                        dces_pkg::OFS_SRC_FG: prdata_r <= fg_r;
                        dces_pkg::OFS_LINE_SCAN: prdata_r <= line_scan_r;
                        dces_pkg::OFS_POLY_LAST: prdata_r <= poly_last_r;
                        dces_pkg::OFS_STATUS: prdata_r <= {11'h000, unpack_busy, launch_op_r, launch_cnt_r};
                        default: prdata_r <= dces_pkg::RST_REG;
                    endcase
                end
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Parameter registers; reserved bits are dropped and read back as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= dces_pkg::RST_REG;
            size_r <= dces_pkg::RST_REG;
            src_r <= dces_pkg::RST_REG;
            tgt_r <= dces_pkg::RST_REG;
            fg_r <= dces_pkg::RST_REG;
            line_scan_r <= dces_pkg::RST_REG;
            poly_last_r <= dces_pkg::RST_REG;
        end else if (wr_fire) begin
            unique case (paddr)
                dces_pkg::OFS_CMD: cmd_r <= pwdata & dces_pkg::CMD_MASK;
                dces_pkg::OFS_RECT_SIZE: size_r <= pwdata & dces_pkg::XY_MASK;
                dces_pkg::OFS_SRC_ORIGIN: src_r <= pwdata & dces_pkg::XY_MASK;
                dces_pkg::OFS_TGT_ORIGIN: tgt_r <= pwdata & dces_pkg::XY_MASK;
                dces_pkg::OFS_SRC_FG: fg_r <= pwdata & dces_pkg::COLOUR_MASK;
                dces_pkg::OFS_LINE_SCAN: line_scan_r <= pwdata;
                dces_pkg::OFS_POLY_LAST: poly_last_r <= pwdata;
                default: ;
            endcase
        end
    end

    // Launch decision: a command word write launches at once unless auto launch is set; otherwise
    // the last parameter register of the stored operation launches it. No-op and reserved codes never draw.
    assign wr_op = (paddr == dces_pkg::OFS_CMD) ? pwdata[dces_pkg::OP_LSB +: 4] : cmd_r[dces_pkg::OP_LSB +: 4];
    assign wr_auto = cmd_r[dces_pkg::AUTO_BIT];
    always_comb begin
        launch_nxt = 1'b0;
        if (wr_fire) begin
            if (paddr == dces_pkg::OFS_CMD) begin
                launch_nxt = ~pwdata[dces_pkg::AUTO_BIT];
            end else if (wr_auto) begin
                launch_nxt = ((paddr == dces_pkg::OFS_TGT_ORIGIN) &&
                              ((wr_op == dces_pkg::OP_COPY) || (wr_op == dces_pkg::OP_FILL))) ||
                             ((paddr == dces_pkg::OFS_LINE_SCAN) && (wr_op == dces_pkg::OP_LINE)) ||
                             ((paddr == dces_pkg::OFS_POLY_LAST) && (wr_op == dces_pkg::OP_POLY));
            end
            if (!((wr_op == dces_pkg::OP_COPY) || (wr_op == dces_pkg::OP_FILL) ||
                  (wr_op == dces_pkg::OP_LINE) || (wr_op == dces_pkg::OP_POLY))) begin
                launch_nxt = 1'b0;
            end
        end
    end

    // Launch pulse, launched code and launch counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            launch_r <= 1'b0;
            launch_op_r <= dces_pkg::OP_NOP;
            launch_cnt_r <= 16'h0000;
            pff_r <= 1'b1;
        end else begin
            launch_r <= launch_nxt;
            if (launch_nxt) begin
                launch_op_r <= wr_op;
                pff_r <= (wr_op != dces_pkg::OP_COPY);
                launch_cnt_r <= launch_cnt_r + 16'h0001;
            end
        end
    end

    // The global enable is sampled so that the output stays a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_use_r <= 1'b0;
        end else begin
            bw_use_r <= global_block_write_enable & ~cmd_r[dces_pkg::BW_INHIBIT_BIT];
        end
    end

    // Next value of the command word, as the register block will store it.
    assign cmd_nxt = (wr_fire && (paddr == dces_pkg::OFS_CMD)) ? (pwdata & dces_pkg::CMD_MASK) : cmd_r;

    // Derived mode flags are decoded from the next command word, so they are flops yet change with it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fres_r <= 1'b0;
            mtr_r <= 1'b0;
            cke_r <= 1'b0;
        end else begin
            fres_r <= cmd_nxt[dces_pkg::FMT_LSB + 2] | (cmd_nxt[dces_pkg::FMT_LSB +: 2] == 2'b11);
            mtr_r <= cmd_nxt[dces_pkg::TRANSP_BIT] & cmd_nxt[dces_pkg::HOST_SRC_BIT] &
                     cmd_nxt[dces_pkg::MONO_SRC_BIT];
            cke_r <= cmd_nxt[dces_pkg::TRANSP_BIT] & cmd_nxt[dces_pkg::HOST_SRC_BIT] &
                     ~cmd_nxt[dces_pkg::MONO_SRC_BIT] &
                     (cmd_nxt[dces_pkg::FMT_LSB +: 3] != dces_pkg::FMT_24);
        end
    end

    // Bytes per image line from the rectangle width, which counts one less than the pixels.
    always_comb begin
        line_bytes = {2'b00, size_r[dces_pkg::X_LSB +: 11]} + 13'h0001;
        if (cmd_r[dces_pkg::MONO_SRC_BIT]) begin
            line_bytes = {5'h00, size_r[dces_pkg::X_LSB + 3 +: 8]} + 13'h0001;
        end else if (cmd_r[dces_pkg::FMT_LSB +: 3] == dces_pkg::FMT_16) begin
            line_bytes = {line_bytes[11:0], 1'b0};
        end else if (cmd_r[dces_pkg::FMT_LSB +: 3] == dces_pkg::FMT_24) begin
            line_bytes = {line_bytes[11:0], 1'b0} + line_bytes;
        end
    end

    // Where the next line begins inside the current doubleword.
    assign at_line_end = (line_left_r == 13'h0001);
    always_comb begin
        unique case (cmd_r[dces_pkg::ALIGN_LSB +: 2])
            dces_pkg::ALIGN_BYTE: ptr_after_line = ptr_r + 3'h1;
            dces_pkg::ALIGN_WORD: ptr_after_line = (ptr_r < dces_pkg::PTR_UPPER) ? dces_pkg::PTR_UPPER
                                                                                 : dces_pkg::PTR_END;
            default: ptr_after_line = dces_pkg::PTR_END; // Reserved code behaves as doubleword.
        endcase
    end

    // Image unpacker: one byte per cycle from each host doubleword; pready holds off the next word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            img_word_r <= dces_pkg::RST_REG;
            ptr_r <= dces_pkg::PTR_END;
            first_dword_r <= 1'b1;
            line_left_r <= 13'h0000;
            byte_valid_r <= 1'b0;
            byte_r <= 8'h00;
            line_end_r <= 1'b0;
        end else begin
            byte_valid_r <= 1'b0;
            line_end_r <= 1'b0;
            // The line length is loaded at the first doubleword, once the launching command word is in place.
            if (launch_nxt) begin
                first_dword_r <= 1'b1;
            end
            if (wr_fire & hit_img & cmd_r[dces_pkg::HOST_SRC_BIT]) begin
                img_word_r <= pwdata;
                first_dword_r <= 1'b0;
                if (first_dword_r) begin
                    line_left_r <= line_bytes;
                end
                ptr_r <= first_dword_r ? {1'b0, cmd_r[dces_pkg::SKIP_LSB +: 2]} : 3'h0;
            end else if (unpack_busy) begin
                byte_valid_r <= 1'b1;
                byte_r <= img_word_r[{ptr_r[1:0], 3'b000} +: 8];
                line_end_r <= at_line_end;
                if (at_line_end) begin
                    ptr_r <= ptr_after_line;
                    line_left_r <= line_bytes;
                end else begin
                    ptr_r <= ptr_r + 3'h1;
                    line_left_r <= line_left_r - 13'h0001;
                end
            end
        end
    end

    // Outputs; command fields come straight from the command word flops, derived flags from their own flops.
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign launch = launch_r;
    assign launch_op = launch_op_r;
    assign dimension_select = cmd_r[dces_pkg::DIM_BIT];
    assign clip_enable = cmd_r[dces_pkg::CLIP_BIT];
    assign target_pixel_format = cmd_r[dces_pkg::FMT_LSB +: 3];
    assign format_reserved = fres_r;
    assign pixel_write_enable = cmd_r[dces_pkg::PIXWR_BIT];
    assign host_image_source = cmd_r[dces_pkg::HOST_SRC_BIT];
    assign mono_source_select = cmd_r[dces_pkg::MONO_SRC_BIT];
    assign mono_pattern_select = cmd_r[dces_pkg::MONO_PAT_BIT];
    assign pattern_force_fg = pff_r;
    assign mono_transparent = mtr_r;
    assign colour_key_enable = cke_r;
    assign block_write_use = bw_use_r;
    assign raster_operation_key = cmd_r[dces_pkg::ROP_LSB +: 8];
    assign x_forward = cmd_r[dces_pkg::XFWD_BIT];
    assign y_forward = cmd_r[dces_pkg::YFWD_BIT];
    assign rect_height = size_r[10:0];
    assign rect_width = size_r[dces_pkg::X_LSB +: 11];
    assign src_y = src_r[10:0];
    assign src_x = src_r[dces_pkg::X_LSB +: 11];
    assign tgt_y = tgt_r[10:0];
    assign tgt_x = tgt_r[dces_pkg::X_LSB +: 11];
    assign source_foreground_colour = fg_r[23:0];
    assign img_byte_valid = byte_valid_r;
    assign img_byte = byte_r;
    assign img_line_end = line_end_r;

    // Sequences shared by the launch checks.
    sequence s_cmd_write_now;
        wr_fire && (paddr == dces_pkg::OFS_CMD) && !pwdata[dces_pkg::AUTO_BIT] &&
        (pwdata[dces_pkg::OP_LSB +: 4] == dces_pkg::OP_FILL);
    endsequence
    sequence s_copy_last_param;
        wr_fire && (paddr == dces_pkg::OFS_TGT_ORIGIN) && cmd_r[dces_pkg::AUTO_BIT] &&
        (cmd_r[dces_pkg::OP_LSB +: 4] == dces_pkg::OP_COPY);
    endsequence

    property p_immediate_launch;
        @(posedge pclk) disable iff (!presetn) s_cmd_write_now |=> launch && (launch_op == dces_pkg::OP_FILL);
    endproperty
    a_immediate_launch: assert property (p_immediate_launch) else $error("Command write did not launch.");

    property p_auto_launch;
        @(posedge pclk) disable iff (!presetn) s_copy_last_param |=> launch ##1 !launch;
    endproperty
    a_auto_launch: assert property (p_auto_launch) else $error("Target origin write did not launch copy.");

    property p_nop_quiet;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && (paddr == dces_pkg::OFS_CMD) && (pwdata[dces_pkg::OP_LSB +: 4] == dces_pkg::OP_NOP)) |=> !launch;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("No-op command launched.");

    property p_auto_no_launch;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && (paddr == dces_pkg::OFS_CMD) && pwdata[dces_pkg::AUTO_BIT]) |=> !launch;
    endproperty
    a_auto_no_launch: assert property (p_auto_no_launch) else $error("Auto launch command word launched.");

    property p_block_write;
        @(posedge pclk) disable iff (!presetn)
        (cmd_r[dces_pkg::BW_INHIBIT_BIT] && $stable(cmd_r)) |=> !block_write_use;
    endproperty
    a_block_write: assert property (p_block_write) else $error("Block write used while inhibited.");

    property p_first_skip;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit_img && host_image_source && first_dword_r) |=>
        (ptr_r == {1'b0, cmd_r[dces_pkg::SKIP_LSB +: 2]});
    endproperty
    a_first_skip: assert property (p_first_skip) else $error("First byte skip not applied.");

    property p_dword_align;
        @(posedge pclk) disable iff (!presetn)
        (unpack_busy && at_line_end && !wr_fire && (cmd_r[dces_pkg::ALIGN_LSB +: 2] == dces_pkg::ALIGN_DWORD))
        |=> !unpack_busy ##1 !img_byte_valid;
    endproperty
    a_dword_align: assert property (p_dword_align) else $error("Doubleword alignment kept bytes.");

    property p_word_align;
        @(posedge pclk) disable iff (!presetn)
        (unpack_busy && at_line_end && !wr_fire && (ptr_r < dces_pkg::PTR_UPPER) &&
         (cmd_r[dces_pkg::ALIGN_LSB +: 2] == dces_pkg::ALIGN_WORD)) |=> (ptr_r == dces_pkg::PTR_UPPER);
    endproperty
    a_word_align: assert property (p_word_align) else $error("Word alignment did not resume.");

    property p_colour_key_24;
        @(posedge pclk) disable iff (!presetn)
        (target_pixel_format == dces_pkg::FMT_24) |-> !colour_key_enable;
    endproperty
    a_colour_key_24: assert property (p_colour_key_24) else $error("Colour key enabled at 24 bit.");
endmodule

// file: verif/dces_host_model.sv
// Host processor model that drives APB register and image window writes.
`timescale 1ns/100ps
module dces_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // The bus idles low so no request is seen before the first task call.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
    end

    // One APB transfer; the request is held until pready is sampled high.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // An 8 bit index goes into both low colour bytes.
    task automatic wr_colour8(input logic [7:0] idx, output logic e);
        logic [31:0] q;
        xfer(1'b1, dces_pkg::OFS_SRC_FG, {16'h0000, idx, idx}, q, e);
    endtask
endmodule

// file: verif/dces_top_tb.sv
// Self-checking testbench of the draw command setup block.
`timescale 1ns/100ps
module dces_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ge, launch, dsel, clip, fres, pwe, hsrc;
    logic msrc, mpat, pff, mtr, cke, bwu, xf, yf, ibv, ile, e;
    logic [31:0] paddr, pwdata, prdata, rd, c;
    logic [3:0] lop;
    logic [2:0] fmt;
    logic [7:0] rop, ib;
    logic [10:0] rh, rw, sx, sy, tx, ty;
    logic [23:0] fg;
    logic [8:0] bytes[$];
    logic [31:0] cv[5] = '{32'h79A6_02A6, 32'hFE59_FFD9, 32'h7800_0294, 32'h7800_0284, 32'h7800_0288};
    logic [31:0] la[3] = '{dces_pkg::OFS_TGT_ORIGIN, dces_pkg::OFS_LINE_SCAN, dces_pkg::OFS_POLY_LAST};
    logic [3:0] lo[3] = '{dces_pkg::OP_COPY, dces_pkg::OP_LINE, dces_pkg::OP_POLY};
    int mismatches, n_compared, nlaunch, n0;

    dces_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dces_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_block_write_enable(ge), .launch(launch), .launch_op(lop), .dimension_select(dsel),
        .clip_enable(clip), .target_pixel_format(fmt), .format_reserved(fres), .pixel_write_enable(pwe),
        .host_image_source(hsrc), .mono_source_select(msrc), .mono_pattern_select(mpat),
        .pattern_force_fg(pff), .mono_transparent(mtr), .colour_key_enable(cke), .block_write_use(bwu),
        .raster_operation_key(rop), .x_forward(xf), .y_forward(yf), .rect_height(rh), .rect_width(rw),
        .src_x(sx), .src_y(sy), .tgt_x(tx), .tgt_y(ty), .source_foreground_colour(fg),
        .img_byte_valid(ibv), .img_byte(ib), .img_line_end(ile));

    // Free-running 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Launch pulses and unpacked bytes are logged where they are sampled.
    always @(posedge pclk) begin
        if (launch === 1'b1) begin
            nlaunch <= nlaunch + 1;
        end
        if (ibv === 1'b1) begin
            bytes.push_back({ile, ib});
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, e);
    endtask

    task automatic rdr(input logic [31:0] a);
        u_host.xfer(1'b0, a, 32'h0000_0000, rd, e);
    endtask

    // Launch count since n0 after the one-cycle launch latency has passed.
    task automatic lchk(input string nm, input int exp);
        repeat (2) @(posedge pclk);
        chk(nm, nlaunch - n0, exp);
        n0 = nlaunch;
    endtask

    // One image doubleword after a launching command; entry k of ex is {line end, byte}.
    task automatic img(input logic [31:0] cw, input logic [31:0] r, input int n, input logic [35:0] ex);
        wr(dces_pkg::OFS_RECT_SIZE, r);
        wr(dces_pkg::OFS_CMD, cw);
        bytes.delete();
        wr(dces_pkg::IMG_WIN1_LO, 32'h4433_2211);
        repeat (8) @(posedge pclk);
        chk("img count", bytes.size(), n);
        for (int k = 0; k < n; k++) begin
            chk("img byte", {23'h0, bytes[k]}, {23'h0, ex[9*k +: 9]});
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run length.
    initial begin
        #(25 * 20000);
        mismatches++;
        summarize();
    end

    initial begin
        presetn = 1'b0;
        ge = 1'b0;
        nlaunch = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdr(dces_pkg::OFS_CMD);
        chk("cmd reset", rd, dces_pkg::RST_REG);
        chk("op reset", lop, dces_pkg::OP_NOP);
        wr(dces_pkg::OFS_RECT_SIZE, 32'hFFFF_FFFF);
        rdr(dces_pkg::OFS_RECT_SIZE);
        chk("rect", rd, dces_pkg::XY_MASK);
        chk("height", rh, 11'h7FF);
        chk("width", rw, 11'h7FF);
        wr(dces_pkg::OFS_SRC_ORIGIN, 32'h0123_0456);
        @(posedge pclk);
        chk("src", {sx, sy}, {11'h123, 11'h456});
        u_host.wr_colour8(8'hA5, e);
        rdr(dces_pkg::OFS_SRC_FG);
        chk("fg", rd, 32'h0000_A5A5);
        chk("fg out", fg, 24'h00_A5A5);
        rdr(32'h0000_0010);
        chk("unmapped err", e, 1'b1);
        chk("unmapped rd", rd, dces_pkg::RST_REG);
        n0 = nlaunch;
        // Every operation code, immediate launch: only the four drawing codes start.
        for (int i = 0; i < 16; i++) begin
            wr(dces_pkg::OFS_CMD, {1'b0, 4'(i), 27'h000_0000});
            lchk("op launch", (i == 0 || i == 2 || i == 3 || i == 5));
            if (i == 0 || i == 2 || i == 3 || i == 5) begin
                chk("op", lop, 4'(i));
                chk("pat fg", pff, i != 0);
            end
        end
        // Auto launch: only the last parameter register of the selected type starts it.
        for (int j = 0; j < 3; j++) begin
            wr(dces_pkg::OFS_CMD, {1'b0, lo[j], 27'h000_0001});
            lchk("auto cmd", 0);
            for (int k = 0; k < 3; k++) begin
                wr(la[k], 32'h0001_0002);
                lchk("auto param", j == k);
            end
        end
        wr(dces_pkg::OFS_CMD, {1'b0, dces_pkg::OP_NOP, 27'h000_0000});
        wr(dces_pkg::OFS_TGT_ORIGIN, 32'h0345_0678);
        lchk("cancel", 0);
        chk("tgt", {tx, ty}, {11'h345, 11'h678});
        // Field decode, derived flags and block write use.
        for (int i = 0; i < 5; i++) begin
            c = cv[i];
            ge <= 1'(i);
            wr(dces_pkg::OFS_CMD, c);
            repeat (2) @(posedge pclk);
            rdr(dces_pkg::OFS_CMD);
            chk("cmd rb", rd, c & dces_pkg::CMD_MASK);
            chk("dir rop", {dsel, yf, xf, rop}, {c[31], c[26:25], c[24:17]});
            chk("pix modes", {mpat, hsrc, msrc, pwe}, c[8:5]);
            chk("fmt clip", {fmt, clip, fres}, {c[4:1], c[4:2] > 3'b010});
            chk("transp", {mtr, cke}, {c[9] & c[7] & c[6],
                c[9] & c[7] & !c[6] & (c[4:2] != 3'b010)});
            chk("bw use", bwu, ge & !c[16]);
        end
        wr(dces_pkg::OFS_CMD, {1'b0, dces_pkg::OP_FILL, 27'h000_0100});
        // Host image unpacking: skip, word, byte and doubleword alignment, 16 and 24 bit, mono, host source off.
        img(32'h0001_1880, 32'h0002_0002, 3, {9'h000, 9'h144, 9'h033, 9'h022});
        img(32'h0000_0480, 32'h0001_0001, 4, {9'h144, 9'h033, 9'h122, 9'h011});
        img(32'h0000_0080, 32'h0002_0002, 4, {9'h044, 9'h133, 9'h022, 9'h011});
        img(32'h0000_0884, 32'h0000_0001, 2, {9'h000, 9'h000, 9'h122, 9'h011});
        img(32'h0000_0888, 32'h0000_0001, 3, {9'h000, 9'h133, 9'h022, 9'h011});
        img(32'h0000_08C0, 32'h000F_0001, 2, {9'h000, 9'h000, 9'h122, 9'h011});
        img(32'h0000_0800, 32'h0002_0002, 0, 36'h0_0000_0000);
        summarize();
    end
endmodule
